// ==== hw/rbs_bank_select.sv ====
// Behaviour
// - After reset the bank-select register reads 0x11.
// - Bit 7 enables access to bank three registers and resets to 0.
// - Bit 6 enables access to bank two registers and resets to 0.
// - Bit 5 enables access to bank one registers and resets to 0.
// - Bit 4 enables access to bank zero registers and resets to 1.
// - The low nibble picks the active bank one-hot and resets to bank zero.
// - Accesses are taken before clocks are stable; RF-status ones are the host's to defer.
// - Bank zero register 0x02 bit 7 is a read-only clock-stable flag, reset 0.
`timescale 1ns/1ps
module rbs_bank_select
  import rbs_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic arst_n_in,
  // Register access from serial port
  input wire logic [6:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  // Status from clock generator pin
  input wire logic clk_stable_in,
  // Read data and bank routing
  output logic [7:0] rdata_out,
  output logic rvalid_out,
  output logic [3:0] bank_out,
  output logic [3:0] bank_access_enable_out,
  output logic bank_ext_hit_out,
  output logic [1:0] bank_idx_out
);
  rbs_sync_if stable_if ();
  logic [7:0] bank_access_select;
  logic [4:0] clock_setting_one;
  logic [7:0] rdata;
  logic rvalid;
  logic ext_hit;
  logic [1:0] idx;
  logic [7:0] next_bank_access_select;
  logic [4:0] next_clock_setting_one;
  logic [7:0] next_rdata;
  logic next_rvalid;
  logic next_ext_hit;
  logic [1:0] next_idx;
  logic sel_hit;
  logic clk_hit;
  logic cur_en;
  rbs_idx_t cur_idx;

  assign stable_if.raw = clk_stable_in;

  rbs_sync u_stable_sync
  (
    .clk_sys_in(clk_sys_in),
    .arst_n_in(arst_n_in),
    .port_if(stable_if)
  );

  always_comb
  begin
    // Codes other than one-hot route as bank zero
    case (bank_access_select[3:0])
      RBS_BANK1: cur_idx = RBS_IDX1;
      RBS_BANK2: cur_idx = RBS_IDX2;
      RBS_BANK3: cur_idx = RBS_IDX3;
      default: cur_idx = RBS_IDX0;
    endcase
    cur_en = bank_access_select[RBS_B0_EN_BIT + int'(cur_idx)];
    sel_hit = (addr_in == RBS_ADDR_BANK_SEL);
    clk_hit = cur_en && (cur_idx == RBS_IDX0) && (addr_in == RBS_ADDR_CLOCK_SETTING_ONE);
    next_bank_access_select = bank_access_select;
    next_clock_setting_one = clock_setting_one;
    next_rdata = 8'h00;
    next_rvalid = rd_en_in;
    next_ext_hit = 1'b0;
    next_idx = cur_idx;
    if (wr_en_in)
    begin
      if (sel_hit)
      begin
        next_bank_access_select = wdata_in;
      end
      else if (clk_hit)
      begin
        next_clock_setting_one = wdata_in[4:0];
      end
      else
      begin
        next_ext_hit = cur_en;
      end
    end
    else if (rd_en_in)
    begin
      if (sel_hit)
      begin
        next_rdata = bank_access_select;
      end
      else if (clk_hit)
      begin
        next_rdata = {stable_if.synced, 2'b00, clock_setting_one};
      end
      else
      begin
        next_ext_hit = cur_en;
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      bank_access_select <= RBS_BANK_SEL_RST;
      clock_setting_one <= RBS_CLOCK_SETTING_ONE_RST[4:0];
      rdata <= 8'h00;
      rvalid <= 1'b0;
      ext_hit <= 1'b0;
      idx <= 2'b00;
    end
    else
    begin
      bank_access_select <= next_bank_access_select;
      clock_setting_one <= next_clock_setting_one;
      rdata <= next_rdata;
      rvalid <= next_rvalid;
      ext_hit <= next_ext_hit;
      idx <= next_idx;
    end
  end

  assign rdata_out = rdata;
  assign rvalid_out = rvalid;
  assign bank_out = bank_access_select[3:0];
  assign bank_access_enable_out = bank_access_select[7:4];
  assign bank_ext_hit_out = ext_hit;
  assign bank_idx_out = idx;

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!arst_n_in);

  // Strobe answers
  read_taken_a: assert property (rd_en_in |=> rvalid_out)
    else $error("read not answered");
  read_pulse_a: assert property (!rd_en_in
    |=> !rvalid_out)
    else $error("read answer stretched");
  rdata_idle_a: assert property (!rd_en_in
    |=> rdata_out == 8'h00)
    else $error("read data left standing");
  hit_idle_a: assert property (!wr_en_in && !rd_en_in
    |=> !bank_ext_hit_out)
    else $error("routing pulse without access");
  ext_read_zero_a: assert property (rd_en_in && !wr_en_in && !sel_hit && !clk_hit
    |=> rdata_out == 8'h00)
    else $error("routed read returned local data");

  // Register updates
  sel_write_a: assert property (wr_en_in && addr_in == RBS_ADDR_BANK_SEL
    |=> bank_access_select == $past(wdata_in))
    else $error("bank select write lost");
  sel_hold_a: assert property (!(wr_en_in && addr_in == RBS_ADDR_BANK_SEL)
    |=> $stable(bank_access_select))
    else $error("bank select changed without write");
  sel_read_a: assert property (rd_en_in && !wr_en_in && addr_in == RBS_ADDR_BANK_SEL
    |=> rdata_out == $past(bank_access_select))
    else $error("bank select read wrong");
  clk_write_a: assert property (wr_en_in && clk_hit
    |=> {3'b000, clock_setting_one} == ($past(wdata_in) & 8'h1f))
    else $error("clock setting write lost");
  clk_hold_a: assert property (!(wr_en_in && clk_hit)
    |=> $stable(clock_setting_one))
    else $error("clock setting changed without write");
  flag_read_a: assert property (bank_out == RBS_BANK0 && bank_access_select[RBS_B0_EN_BIT] && rd_en_in
    && !wr_en_in && addr_in == RBS_ADDR_CLOCK_SETTING_ONE
    |=> rdata_out[RBS_CLK_DONE_BIT] == $past(stable_if.synced) && rdata_out[6:5] == 2'b00)
    else $error("clock flag read wrong");
  sync_rise_a: assert property ($rose(stable_if.synced)
    |-> $past(clk_stable_in, 2))
    else $error("clock flag rose early");

  // Bank gating and routing
  b3_gate_a: assert property (bank_out == RBS_BANK3 && !bank_access_select[RBS_B3_EN_BIT]
    && addr_in != RBS_ADDR_BANK_SEL |=> !bank_ext_hit_out)
    else $error("bank3 access leaked");
  b2_gate_a: assert property (bank_out == RBS_BANK2 && !bank_access_select[RBS_B2_EN_BIT]
    && addr_in != RBS_ADDR_BANK_SEL |=> !bank_ext_hit_out)
    else $error("bank2 access leaked");
  b1_gate_a: assert property (bank_out == RBS_BANK1 && !bank_access_select[RBS_B1_EN_BIT]
    && addr_in != RBS_ADDR_BANK_SEL |=> !bank_ext_hit_out)
    else $error("bank1 access leaked");
  b0_gate_a: assert property (bank_out == RBS_BANK0 && !bank_access_select[RBS_B0_EN_BIT]
    && addr_in != RBS_ADDR_BANK_SEL |=> !bank_ext_hit_out && rdata_out == 8'h00)
    else $error("bank0 access leaked");
  b3_pass_a: assert property ((wr_en_in || rd_en_in) && bank_out == RBS_BANK3
    && bank_access_select[RBS_B3_EN_BIT] && addr_in != RBS_ADDR_BANK_SEL
    |=> bank_ext_hit_out && bank_idx_out == RBS_IDX3)
    else $error("bank3 access dropped");
  b2_pass_a: assert property ((wr_en_in || rd_en_in) && bank_out == RBS_BANK2
    && bank_access_select[RBS_B2_EN_BIT] && addr_in != RBS_ADDR_BANK_SEL
    |=> bank_ext_hit_out && bank_idx_out == RBS_IDX2)
    else $error("bank2 access dropped");
  b1_pass_a: assert property ((wr_en_in || rd_en_in) && bank_out == RBS_BANK1
    && bank_access_select[RBS_B1_EN_BIT] && addr_in != RBS_ADDR_BANK_SEL
    |=> bank_ext_hit_out && bank_idx_out == RBS_IDX1)
    else $error("bank1 access dropped");
  b0_pass_a: assert property ((wr_en_in || rd_en_in) && bank_out == RBS_BANK0
    && bank_access_select[RBS_B0_EN_BIT] && addr_in != RBS_ADDR_BANK_SEL && addr_in != RBS_ADDR_CLOCK_SETTING_ONE
    |=> bank_ext_hit_out && bank_idx_out == RBS_IDX0)
    else $error("bank0 access dropped");

  // Reset values
  reset_val_a: assert property ($rose(arst_n_in) |-> bank_access_select == RBS_BANK_SEL_RST)
    else $error("bank select reset wrong");
  reset_en_a: assert property ($rose(arst_n_in)
    |-> bank_access_enable_out == RBS_BANK_SEL_RST[7:4] && bank_out == RBS_BANK_SEL_RST[3:0])
    else $error("bank enables reset wrong");

  // Main scenarios
  bank_switch_c: cover property (wr_en_in && addr_in == RBS_ADDR_BANK_SEL ##1 bank_out == RBS_BANK3);
  ext_access_c: cover property (bank_ext_hit_out && bank_idx_out == RBS_IDX2);
  flag_set_c: cover property (rvalid_out && rdata_out[RBS_CLK_DONE_BIT]);
  closed_bank_c: cover property (rd_en_in && !cur_en ##1 rvalid_out && !bank_ext_hit_out);
  clk_write_c: cover property (wr_en_in && clk_hit ##1 clock_setting_one != RBS_CLOCK_SETTING_ONE_RST[4:0]);
endmodule

// ==== include/rbs_pkg.sv ====
package rbs_pkg;
  // Register map
  localparam logic [6:0] RBS_ADDR_BANK_SEL = 7'h00;
  localparam logic [6:0] RBS_ADDR_CLOCK_SETTING_ONE = 7'h02;
  localparam logic [7:0] RBS_BANK_SEL_RST = 8'h11;
  localparam logic [7:0] RBS_CLOCK_SETTING_ONE_RST = 8'h1f;
  // Bank-select fields and the clock-stable flag bit of register 0x02
  localparam int RBS_B3_EN_BIT = 7;
  localparam int RBS_B2_EN_BIT = 6;
  localparam int RBS_B1_EN_BIT = 5;
  localparam int RBS_B0_EN_BIT = 4;
  localparam int RBS_CLK_DONE_BIT = 7;
  localparam logic [3:0] RBS_BANK0 = 4'h1;
  localparam logic [3:0] RBS_BANK1 = 4'h2;
  localparam logic [3:0] RBS_BANK2 = 4'h4;
  localparam logic [3:0] RBS_BANK3 = 4'h8;
  // Bank index encoding
  typedef enum logic [1:0]
  {
    RBS_IDX0 = 2'b00,
    RBS_IDX1 = 2'b01,
    RBS_IDX2 = 2'b10,
    RBS_IDX3 = 2'b11
  } rbs_idx_t;
endpackage

// ==== include/rbs_sync_if.sv ====
`timescale 1ns/1ps
interface rbs_sync_if;
  logic raw;
  logic synced;
  modport sync (input raw, output synced);
  modport user (output raw, input synced);
endinterface

// ==== hw/rbs_sync.sv ====
`timescale 1ns/1ps
module rbs_sync
  import rbs_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic arst_n_in,
  // Level
  rbs_sync_if.sync port_if
);
  logic stage1;
  logic stage2;
  logic next_stage1;
  logic next_stage2;

  always_comb
  begin
    next_stage1 = port_if.raw;
    next_stage2 = stage1;
  end

  always_ff @(posedge clk_sys_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
    end
    else
    begin
      stage1 <= next_stage1;
      stage2 <= next_stage2;
    end
  end

  assign port_if.synced = stage2;
endmodule

// ==== verification/rbs_host.sv ====
`timescale 1ns/1ps
module rbs_host
(
  // Clock
  input wire logic clk_sys_in,
  // Answers from the device
  input wire logic [7:0] rdata_in,
  input wire logic rvalid_in,
  input wire logic hit_in,
  // Register access
  output logic [6:0] addr_out,
  output logic [7:0] wdata_out,
  output logic wr_out,
  output logic rd_out
);
  initial
  begin
    addr_out = 7'h7f;
    wdata_out = 8'h00;
    wr_out = 1'b0;
    rd_out = 1'b0;
  end

  // Callers pass only one-hot bank codes and listed registers; no calibration runs here
  task automatic wr_reg(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    addr_out <= a;
    wdata_out <= d;
    wr_out <= 1'b1;
    @(posedge clk_sys_in);
    wr_out <= 1'b0;
    addr_out <= ~a;
    wdata_out <= ~d;
  endtask

  // RF-status registers are never touched by this host
  task automatic rd_reg(input logic [6:0] a, output logic [7:0] d, output logic v, output logic h);
    @(posedge clk_sys_in);
    addr_out <= a;
    rd_out <= 1'b1;
    @(posedge clk_sys_in);
    rd_out <= 1'b0;
    addr_out <= ~a;
    @(posedge clk_sys_in);
    d = rdata_in;
    v = rvalid_in;
    h = hit_in;
  endtask
endmodule

// ==== verification/register_bank_select_access_test.sv ====
`timescale 1ns/1ps
module register_bank_select_access_test;
  import rbs_pkg::*;
  logic clk_sys_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic clk_stable_in = 1'b0;
  logic [6:0] addr;
  logic [7:0] wdata, rdata, d;
  logic wr, rd, rvalid, hit, v, h;
  logic [3:0] bank, en;
  logic [1:0] idx;
  // One listed register per bank
  logic [6:0] ext_addr [4] = '{7'h03, 7'h42, 7'h40, 7'h23};
  int error_cnt = 0;
  int cmp_count = 0;
  int cyc = 0;

  always #20 clk_sys_in = ~clk_sys_in;

  rbs_bank_select dut (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in), .addr_in(addr), .wdata_in(wdata),
    .wr_en_in(wr), .rd_en_in(rd), .clk_stable_in(clk_stable_in), .rdata_out(rdata), .rvalid_out(rvalid),
    .bank_out(bank), .bank_access_enable_out(en), .bank_ext_hit_out(hit), .bank_idx_out(idx));

  rbs_host host (.clk_sys_in(clk_sys_in), .rdata_in(rdata), .rvalid_in(rvalid), .hit_in(hit),
    .addr_out(addr), .wdata_out(wdata), .wr_out(wr), .rd_out(rd));

  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    cmp_count++;
    if (s !== e)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  always @(posedge clk_sys_in)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      error_cnt++;
      complete_run();
    end
  end

  initial
  begin
    repeat (3) @(posedge clk_sys_in);
    arst_n_in <= 1'b1;
    chk("bank", {4'h0, bank}, 8'h01);
    chk("enables", {4'h0, en}, 8'h01);
    host.rd_reg(RBS_ADDR_BANK_SEL, d, v, h);
    chk("bank_select", d, 8'h11);
    // Flag still low, access must still be taken
    host.rd_reg(RBS_ADDR_CLOCK_SETTING_ONE, d, v, h);
    chk("clock_setting_one", d, 8'h1f);
    chk("rvalid", {7'h0, v}, 8'h01);
    @(posedge clk_sys_in);
    clk_stable_in <= 1'b1;
    repeat (3) @(posedge clk_sys_in);
    host.rd_reg(RBS_ADDR_CLOCK_SETTING_ONE, d, v, h);
    chk("clock_setting_one", d, 8'h9f);
    // Flag and reserved bits ignore writes
    host.wr_reg(RBS_ADDR_CLOCK_SETTING_ONE, 8'h65);
    host.rd_reg(RBS_ADDR_CLOCK_SETTING_ONE, d, v, h);
    chk("clock_setting_one", d, 8'h85);
    chk("ext_hit", {7'h0, h}, 8'h00);
    // Each bank selected with only its own enable set
    for (int i = 0; i < 4; i++)
    begin
      host.wr_reg(RBS_ADDR_BANK_SEL, (8'h10 << i) | (8'h01 << i));
      host.rd_reg(RBS_ADDR_BANK_SEL, d, v, h);
      chk("bank_select", d, (8'h10 << i) | (8'h01 << i));
      chk("bank", {4'h0, bank}, 8'h01 << i);
      chk("enables", {4'h0, en}, 8'h01 << i);
      host.rd_reg(ext_addr[i], d, v, h);
      chk("ext_hit", {7'h0, h}, 8'h01);
      chk("rdata", d, 8'h00);
      chk("bank_idx", {6'h0, idx}, i[7:0]);
    end
    // Each bank selected with its enable cleared
    for (int i = 0; i < 4; i++)
    begin
      host.wr_reg(RBS_ADDR_BANK_SEL, 8'h01 << i);
      host.rd_reg(ext_addr[i], d, v, h);
      chk("ext_hit", {7'h0, h}, 8'h00);
      chk("rdata", d, 8'h00);
      chk("rvalid", {7'h0, v}, 8'h01);
    end
    // Bank zero closed: clock register unreachable, bank select still reachable
    host.wr_reg(RBS_ADDR_BANK_SEL, 8'h01);
    host.rd_reg(RBS_ADDR_CLOCK_SETTING_ONE, d, v, h);
    chk("rdata", d, 8'h00);
    chk("ext_hit", {7'h0, h}, 8'h00);
    host.rd_reg(RBS_ADDR_BANK_SEL, d, v, h);
    chk("bank_select", d, 8'h01);
    complete_run();
  end
endmodule
